// ---- hdl/uart_event_pkg.sv ----
package uart_event_pkg;
	// ----------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------
	localparam logic [4:0] ADDR_SUMMARY  = 5'h02;
	localparam logic [4:0] ADDR_SC_EN    = 5'h05;
	localparam logic [4:0] ADDR_SC_FLAGS = 5'h06;
	localparam logic [4:0] ADDR_ST_EN    = 5'h07;
	localparam logic [4:0] ADDR_ST_FLAGS = 5'h08;
	localparam logic [4:0] ADDR_FIRST_MODE_CONTROL    = 5'h09;
	// ----------------------------------------------------------
	// field layout and reset values
	// ----------------------------------------------------------
	localparam logic [7:0] REG_RESET     = 8'h00;
	localparam logic [7:0] SC_MASK       = 8'h3F;
	localparam logic [7:0] ST_MASK       = 8'h6F;
	localparam logic [3:0] GPI_RESET     = 4'h0;
	localparam int SUM_SPECIAL_BIT  = 1;
	localparam int SUM_STATUS_BIT   = 2;
	localparam int SUM_TX_EMPTY_BIT = 5;
	localparam int ST_SLEEP_BIT     = 6;
	localparam int ST_CLOCK_BIT     = 5;
	localparam int M_IRQ_SEL        = 7;
	localparam int M_AUTOSLEEP      = 6;
	localparam int M_MANUAL_SLEEP   = 5;
	localparam int M_AUTO_DIR       = 4;
	localparam int M_DIR_FLOAT      = 3;
	localparam int M_TX_FLOAT       = 2;
	localparam int M_TX_OFF         = 1;
	localparam int M_RX_OFF         = 0;
	localparam int SPI_WRITE_BIT    = 7;
	// ----------------------------------------------------------
	// timing
	// ----------------------------------------------------------
	localparam int CLOCK_PERIOD_NS  = 25;
	localparam int POWERUP_NS       = 2000;
	localparam int POWERUP_CYCLES   =
		(POWERUP_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
	localparam int DELAY_UNIT_NS    = 500;
	localparam int DELAY_UNIT_CYCLES =
		(DELAY_UNIT_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
	localparam int AUTOSLEEP_DEFAULT = 40000;
	typedef enum {DIR_RECEIVE, DIR_SETUP, DIR_SEND, DIR_HOLD}
		direction_type;
endpackage

// ---- hdl/spi_register_port.sv ----
`timescale 1ns/1ps
module spi_register_port
	import uart_event_pkg::*;
(
	input  wire logic       clock,
	input  wire logic       sys_rst,
	input  wire logic       cs_n_pin,
	input  wire logic       sclk_pin,
	input  wire logic       mosi_pin,
	input  wire logic [7:0] rdata,
	output logic            miso,
	output logic            miso_en,
	output logic            wr_pulse,
	output logic            rd_pulse,
	output logic [4:0]      addr,
	output logic [7:0]      wdata
);
	// ----------------------------------------------------------
	// pin synchronisers: accept a level once stages two and three agree
	// ----------------------------------------------------------
	logic [2:0] sync1;
	logic [2:0] sync2;
	logic [2:0] sync3;
	logic [2:0] level;
	logic       sclk_prev;
	logic [4:0] count;
	logic [7:0] shift_in;
	logic [7:0] shift_out;
	logic       is_write;
	logic       rise;
	logic       fall;
	logic       selected;

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			sync1 <= 3'h1;
			sync2 <= 3'h1;
			sync3 <= 3'h1;
			level <= 3'h1;
			sclk_prev <= 1'b0;
		end else begin
			sync1 <= {sclk_pin, mosi_pin, cs_n_pin};
			sync2 <= sync1;
			sync3 <= sync2;
			level <= (sync2 & sync3) | (level & (sync2 ^ sync3));
			sclk_prev <= level[2];
		end
	end

	assign selected = ~level[0];
	assign rise = selected & level[2] & ~sclk_prev;
	assign fall = selected & ~level[2] & sclk_prev;

	// ----------------------------------------------------------
	// frame: command byte (write flag, address) then data byte
	// ----------------------------------------------------------
	always_ff @(posedge clock) begin
		if (sys_rst || !selected) begin
			count <= 5'h00;
			shift_in <= 8'h00;
		end else if (rise) begin
			shift_in <= {shift_in[6:0], level[1]};
			count <= (count == 5'h10) ? count : count + 5'h01;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			wr_pulse <= 1'b0;
			rd_pulse <= 1'b0;
			addr <= 5'h00;
			wdata <= 8'h00;
			is_write <= 1'b0;
		end else begin
			wr_pulse <= 1'b0;
			rd_pulse <= 1'b0;
			if (rise && count == 5'h07) begin
				addr <= {shift_in[3:0], level[1]};
				is_write <= shift_in[SPI_WRITE_BIT - 1];
				rd_pulse <= ~shift_in[SPI_WRITE_BIT - 1];
			end
			if (rise && count == 5'h0F && is_write) begin
				wdata <= {shift_in[6:0], level[1]};
				wr_pulse <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------
	// read data leaves on falling clock edges, msb first
	// ----------------------------------------------------------
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			shift_out <= 8'h00;
			miso <= 1'b0;
			miso_en <= 1'b0;
		end else begin
			miso_en <= selected;
			if (fall && count == 5'h08) begin
				shift_out <= {rdata[6:0], 1'b0};
				miso <= rdata[7];
			end else if (fall && count > 5'h08) begin
				shift_out <= {shift_out[6:0], 1'b0};
				miso <= shift_out[7];
			end
		end
	end
endmodule

// ---- hdl/uart_event_and_mode_control.sv ----
`timescale 1ns/1ps
// Function
// - each special enable bit routes its flag into summary bit 1
// - address character in multidrop mode sets flag 5; read clears
// - line break sets flag 4; read clears
// - with detection on, stop and resume characters set bits 3..0
// - sleep enable routes sleep status into summary bit 2
// - clock-settled enable routes clock status into summary bit 2
// - each input-change enable routes its flag into summary bit 2
// - sleep status follows sleep state, cleared by clock off, not read
// - clock status sets once settled on own oscillator; read keeps
// - input-change flags set on any input edge; read clears
// - after reset irq select is 0; pin low until ready
// - with irq select set, pin shows pending summary interrupts
// - autosleep enters sleep after idle; events on sleep and wake
// - manual sleep bit forces sleep; reads return present state
// - direction output low for receive, high while data queued
// - setup and hold delays applied; summary bit 5 on empty
// - mode bit 3 floats the direction output pin
// - mode bit 2 floats the transmit output pin
// - transmit off finishes current character then holds line high
// - receive off stops accepting data, queued data kept
// - summary bit 2 set by enabled status source; read clears
// - summary bit 1 set by enabled special event; read clears
module uart_event_and_mode_control
	import uart_event_pkg::*;
#(
	parameter int AUTOSLEEP_CYCLES = AUTOSLEEP_DEFAULT
)(
	input  wire logic       CLOCK,
	input  wire logic       SYS_RST,
	input  wire logic       SOFT_RESET,
	input  wire logic       SPI_CS_N,
	input  wire logic       SPI_SCLK,
	input  wire logic       SPI_MOSI,
	output logic            SPI_MISO,
	output logic            SPI_MISO_EN,
	input  wire logic       ADDRESS_CHAR_EVENT,
	input  wire logic       LINE_BREAK_EVENT,
	input  wire logic       STOP_CHAR_TWO_EVENT,
	input  wire logic       STOP_CHAR_ONE_EVENT,
	input  wire logic       RESUME_CHAR_TWO_EVENT,
	input  wire logic       RESUME_CHAR_ONE_EVENT,
	input  wire logic       MULTIDROP_MODE,
	input  wire logic       SPECIAL_DETECT,
	input  wire logic       CLOCK_SETTLED,
	input  wire logic       EXTERNAL_CLOCK,
	input  wire logic       CLOCK_DISABLED,
	input  wire logic [3:0] GPI,
	input  wire logic       LINE_ACTIVITY,
	input  wire logic       TX_QUEUED,
	input  wire logic       TX_BUSY,
	input  wire logic       TX_EMPTY,
	input  wire logic       TX_SERIAL,
	input  wire logic       RTS_LEVEL,
	input  wire logic [7:0] HALF_DUPLEX_DELAYS,
	output logic            IRQ_N,
	output logic            DIRECTION_OR_CLOCK_OUTPUT,
	output logic            DIRECTION_OUTPUT_EN,
	output logic            TX_PIN,
	output logic            TX_PIN_EN,
	output logic            TX_GRANT,
	output logic            RX_ACCEPT,
	output logic            SLEEP_ACTIVE
);
	logic          reset;
	logic          wr_pulse;
	logic          rd_pulse;
	logic [4:0]    addr;
	logic [7:0]    wdata;
	logic [7:0]    read_data;
	logic [7:0]    sc_en;
	logic [7:0]    sc_flags;
	logic [7:0]    st_en;
	logic [3:0]    gpi_flags;
	logic          sleep_flag;
	logic          clock_flag;
	logic [7:0]    first_mode_control;
	logic [7:0]    summary;
	logic [5:0]    sc_set;
	logic [3:0]    gpi_sync1;
	logic [3:0]    gpi_sync2;
	logic [3:0]    gpi_sync3;
	logic [3:0]    gpi_level;
	logic [3:0]    gpi_change;
	logic [7:0]    st_view;
	logic          status_any;
	logic          status_any_prev;
	logic          sleep_state;
	logic          sleep_prev;
	logic          auto_asleep;
	logic [31:0]   idle_count;
	logic [15:0]   powerup_count;
	logic          power_ready;
	logic          tx_empty_prev;
	logic [7:0]    unit_count;
	logic          delay_tick;
	logic [3:0]    wait_count;
	direction_type state;
	direction_type next_state;

	assign reset = SYS_RST | SOFT_RESET;

	spi_register_port port (
		.clock    (CLOCK),
		.sys_rst  (SYS_RST),
		.cs_n_pin (SPI_CS_N),
		.sclk_pin (SPI_SCLK),
		.mosi_pin (SPI_MOSI),
		.rdata    (read_data),
		.miso     (SPI_MISO),
		.miso_en  (SPI_MISO_EN),
		.wr_pulse (wr_pulse),
		.rd_pulse (rd_pulse),
		.addr     (addr),
		.wdata    (wdata)
	);

	// ----------------------------------------------------------
	// writable registers
	// ----------------------------------------------------------
	always_ff @(posedge CLOCK) begin
		if (reset) begin
			sc_en <= REG_RESET;
			st_en <= REG_RESET;
			first_mode_control <= REG_RESET;
		end else if (wr_pulse) begin
			case (addr)
				ADDR_SC_EN: sc_en <= wdata & SC_MASK;
				ADDR_ST_EN: st_en <= wdata & ST_MASK;
				ADDR_FIRST_MODE_CONTROL: first_mode_control <= wdata;
				default: ;
			endcase
		end
	end

	// ----------------------------------------------------------
	// read mux; captured on the read command
	// ----------------------------------------------------------
	assign st_view = {1'b0, sleep_flag, clock_flag, 1'b0, gpi_flags};

	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			read_data <= REG_RESET;
		end else if (rd_pulse) begin
			case (addr)
				ADDR_SUMMARY:  read_data <= summary;
				ADDR_SC_EN:    read_data <= sc_en;
				ADDR_SC_FLAGS: read_data <= sc_flags;
				ADDR_ST_EN:    read_data <= st_en;
				ADDR_ST_FLAGS: read_data <= st_view;
				ADDR_FIRST_MODE_CONTROL:    read_data <= {first_mode_control[7:6], sleep_state,
					first_mode_control[4:0]};
				default:       read_data <= REG_RESET;
			endcase
		end
	end

	// ----------------------------------------------------------
	// special character flags
	// ----------------------------------------------------------
	assign sc_set = {ADDRESS_CHAR_EVENT & MULTIDROP_MODE,
		LINE_BREAK_EVENT,
		{STOP_CHAR_TWO_EVENT, STOP_CHAR_ONE_EVENT,
		RESUME_CHAR_TWO_EVENT, RESUME_CHAR_ONE_EVENT}
		& {4{SPECIAL_DETECT}}};

	always_ff @(posedge CLOCK) begin
		if (reset) begin
			sc_flags <= REG_RESET;
		end else if (rd_pulse && addr == ADDR_SC_FLAGS) begin
			sc_flags <= {2'b00, sc_set};
		end else begin
			sc_flags <= sc_flags | {2'b00, sc_set};
		end
	end

	// ----------------------------------------------------------
	// status flags
	// ----------------------------------------------------------
	always_ff @(posedge CLOCK) begin
		if (reset) begin
			// chain tracks the pins in reset: no false change after it
			gpi_sync1 <= GPI;
			gpi_sync2 <= gpi_sync1;
			gpi_sync3 <= gpi_sync2;
			gpi_level <= gpi_sync3;
			gpi_change <= GPI_RESET;
		end else begin
			gpi_sync1 <= GPI;
			gpi_sync2 <= gpi_sync1;
			gpi_sync3 <= gpi_sync2;
			gpi_level <= (gpi_sync2 & gpi_sync3)
				| (gpi_level & (gpi_sync2 ^ gpi_sync3));
			gpi_change <= gpi_level ^ ((gpi_sync2 & gpi_sync3)
				| (gpi_level & (gpi_sync2 ^ gpi_sync3)));
		end
	end

	always_ff @(posedge CLOCK) begin
		if (reset) begin
			gpi_flags <= GPI_RESET;
		end else if (rd_pulse && addr == ADDR_ST_FLAGS) begin
			gpi_flags <= gpi_change;
		end else begin
			gpi_flags <= gpi_flags | gpi_change;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (reset) begin
			sleep_flag <= 1'b0;
			clock_flag <= 1'b0;
		end else begin
			sleep_flag <= sleep_state & ~CLOCK_DISABLED;
			if (CLOCK_DISABLED) begin
				clock_flag <= 1'b0;
			end else if (CLOCK_SETTLED && !EXTERNAL_CLOCK) begin
				clock_flag <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------
	// sleep: manual and after idle
	// ----------------------------------------------------------
	always_ff @(posedge CLOCK) begin
		if (reset) begin
			idle_count <= 32'h0;
			auto_asleep <= 1'b0;
			sleep_state <= 1'b0;
		end else begin
			sleep_state <= first_mode_control[M_MANUAL_SLEEP] | auto_asleep;
			if (!first_mode_control[M_AUTOSLEEP] || LINE_ACTIVITY || TX_QUEUED
				|| TX_BUSY || wr_pulse) begin
				idle_count <= 32'h0;
				auto_asleep <= 1'b0;
			end else if (idle_count == 32'(AUTOSLEEP_CYCLES - 1)) begin
				auto_asleep <= 1'b1;
			end else begin
				idle_count <= idle_count + 32'h1;
			end
		end
	end

	// ----------------------------------------------------------
	// summary register
	// ----------------------------------------------------------
	assign status_any = |(st_view & st_en);

	always_ff @(posedge CLOCK) begin
		if (reset) begin
			summary <= REG_RESET;
			status_any_prev <= 1'b0;
			sleep_prev <= 1'b0;
			tx_empty_prev <= 1'b1;
		end else begin
			status_any_prev <= status_any;
			sleep_prev <= sleep_flag;
			tx_empty_prev <= TX_EMPTY;
			if (rd_pulse && addr == ADDR_SUMMARY) begin
				summary <= REG_RESET;
			end
			if (|(sc_set & sc_en[5:0])) begin
				summary[SUM_SPECIAL_BIT] <= 1'b1;
			end
			if ((status_any && !status_any_prev) || (st_en[ST_SLEEP_BIT]
				&& sleep_flag != sleep_prev)) begin
				summary[SUM_STATUS_BIT] <= 1'b1;
			end
			if (TX_EMPTY && !tx_empty_prev) begin
				summary[SUM_TX_EMPTY_BIT] <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------
	// interrupt pin
	// ----------------------------------------------------------
	always_ff @(posedge CLOCK) begin
		if (reset) begin
			powerup_count <= 16'(POWERUP_CYCLES);
			power_ready <= 1'b0;
			IRQ_N <= 1'b0;
		end else begin
			if (powerup_count != 16'h0) begin
				powerup_count <= powerup_count - 16'h1;
			end
			power_ready <= (powerup_count == 16'h0);
			if (!first_mode_control[M_IRQ_SEL]) begin
				IRQ_N <= power_ready;
			end else begin
				IRQ_N <= ~(|summary);
			end
		end
	end

	// ----------------------------------------------------------
	// direction control with setup and hold delays
	// ----------------------------------------------------------
	always_ff @(posedge CLOCK) begin
		// restarts with each delay so its first unit is a whole unit
		if (reset || state == DIR_RECEIVE || state == DIR_SEND
			|| unit_count == 8'(DELAY_UNIT_CYCLES - 1)) begin
			unit_count <= 8'h00;
		end else begin
			unit_count <= unit_count + 8'h01;
		end
	end

	assign delay_tick = (unit_count == 8'(DELAY_UNIT_CYCLES - 1));

	always_comb begin
		next_state = state;
		case (state)
			DIR_RECEIVE: if (TX_QUEUED) next_state = DIR_SETUP;
			DIR_SETUP:   if (wait_count == 4'h0) next_state = DIR_SEND;
			DIR_SEND:    if (TX_EMPTY && !TX_BUSY) next_state = DIR_HOLD;
			DIR_HOLD:    if (wait_count == 4'h0) next_state = DIR_RECEIVE;
			default:     next_state = DIR_RECEIVE;
		endcase
		if (!first_mode_control[M_AUTO_DIR]) begin
			next_state = DIR_RECEIVE;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (reset) begin
			state <= DIR_RECEIVE;
			wait_count <= 4'h0;
		end else begin
			state <= next_state;
			if (state == DIR_RECEIVE) begin
				wait_count <= HALF_DUPLEX_DELAYS[7:4];
			end else if (state == DIR_SEND) begin
				wait_count <= HALF_DUPLEX_DELAYS[3:0];
			end else if (delay_tick && wait_count != 4'h0) begin
				wait_count <= wait_count - 4'h1;
			end
		end
	end

	// ----------------------------------------------------------
	// pin drivers and transfer permits
	// ----------------------------------------------------------
	always_ff @(posedge CLOCK) begin
		if (reset) begin
			DIRECTION_OR_CLOCK_OUTPUT <= 1'b0;
			DIRECTION_OUTPUT_EN <= 1'b0;
			TX_PIN <= 1'b1;
			TX_PIN_EN <= 1'b0;
			TX_GRANT <= 1'b0;
			RX_ACCEPT <= 1'b0;
			SLEEP_ACTIVE <= 1'b0;
		end else begin
			DIRECTION_OR_CLOCK_OUTPUT <= first_mode_control[M_AUTO_DIR]
				? (state != DIR_RECEIVE) : RTS_LEVEL;
			DIRECTION_OUTPUT_EN <= ~first_mode_control[M_DIR_FLOAT];
			TX_PIN_EN <= ~first_mode_control[M_TX_FLOAT];
			TX_PIN <= (first_mode_control[M_TX_OFF] && !TX_BUSY) ? 1'b1
				: TX_SERIAL;
			TX_GRANT <= ~first_mode_control[M_TX_OFF] & ~sleep_state
				& (~first_mode_control[M_AUTO_DIR] | (state == DIR_SEND));
			RX_ACCEPT <= ~first_mode_control[M_RX_OFF];
			SLEEP_ACTIVE <= sleep_state;
		end
	end

	// ----------------------------------------------------------
	// checks
	// ----------------------------------------------------------
	default clocking chk @(posedge CLOCK); endclocking
	default disable iff (reset);

	sequence dir_start;
		(state == DIR_RECEIVE && first_mode_control[M_AUTO_DIR] && TX_QUEUED)
		##1 (state == DIR_SETUP && first_mode_control[M_AUTO_DIR]);
	endsequence

	special_read_clear_a: assert property (
		(rd_pulse && addr == ADDR_SC_FLAGS && sc_set == 6'h00)
		|=> sc_flags == REG_RESET)
		else $error("special flags not cleared by read");
	special_set_a: assert property (
		(sc_set != 6'h00) |=> ((sc_flags[5:0] & $past(sc_set))
		== $past(sc_set)))
		else $error("special event lost");
	special_summary_a: assert property (
		(|(sc_set & sc_en[5:0])) |=> summary[SUM_SPECIAL_BIT])
		else $error("enabled special event missing in summary");
	status_summary_a: assert property (
		(status_any && !status_any_prev) |=> summary[SUM_STATUS_BIT])
		else $error("enabled status missing in summary");
	clock_flag_a: assert property (
		CLOCK_DISABLED |=> !clock_flag)
		else $error("clock status kept with clock off");
	gpi_change_a: assert property (
		(gpi_change != 4'h0) |=> ((gpi_flags & $past(gpi_change))
		== $past(gpi_change)))
		else $error("input change lost");
	irq_powerup_a: assert property (
		(!power_ready && !first_mode_control[M_IRQ_SEL]) |=> !IRQ_N)
		else $error("interrupt pin high during power-up");
	direction_setup_a: assert property (
		dir_start |=> DIRECTION_OR_CLOCK_OUTPUT)
		else $error("direction output not raised for queued data");
	tx_float_a: assert property (
		first_mode_control[M_TX_FLOAT] |=> !TX_PIN_EN)
		else $error("transmit pin driven while floated");
endmodule

// ---- testbench/spi_host_model.sv ----
`timescale 1ns/1ps
module spi_host_model (
	input  wire logic clock,
	input  wire logic miso,
	output logic      cs_n,
	output logic      sclk,
	output logic      mosi
);
	// ----------------------------------------------------------
	// host side of the register port: mode 0, msb first
	// ----------------------------------------------------------
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		mosi = 1'b0;
	end

	// one 16-bit frame, called at a falling clock edge
	task automatic xfer(input logic wr, input logic [4:0] a,
		input logic [7:0] d, output logic [7:0] q);
		logic [15:0] sh;
		sh = {wr, 2'b00, a, d};
		q = 8'h00;
		cs_n = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			mosi = sh[i];
			repeat (10) @(negedge clock);
			q = {q[6:0], miso};
			sclk = 1'b1;
			repeat (10) @(negedge clock);
			sclk = 1'b0;
		end
		repeat (10) @(negedge clock);
		cs_n = 1'b1;
		// no stale level on the data line between frames
		mosi = ~mosi;
		repeat (10) @(negedge clock);
	endtask
endmodule

// ---- testbench/tb_uart_event_and_mode_control.sv ----
`timescale 1ns/1ps
module tb_uart_event_and_mode_control;
	import uart_event_pkg::*;
	logic       clock, sys_rst, soft_reset, cs_n, sclk, mosi;
	logic       miso, miso_en, multidrop, special, settled;
	logic       ext_clk, clk_off, activity, tx_queued, tx_busy;
	logic       tx_empty, tx_serial, rts_level;
	logic [5:0] ev;
	logic [3:0] gpi;
	logic [7:0] hd_delays, en;
	logic       irq_n, dir_out, dir_en, tx_pin, tx_en, tx_grant;
	logic       rx_accept, sleep_active;
	integer     seed;
	int         err_count, n_checks;
	int         en_miss = 0;
	wire  [7:0] outs = {irq_n, dir_out, dir_en, tx_pin, tx_en,
		tx_grant, rx_accept, sleep_active};

	spi_host_model host (.clock(clock), .miso(miso), .cs_n(cs_n),
		.sclk(sclk), .mosi(mosi));

	uart_event_and_mode_control #(.AUTOSLEEP_CYCLES(20)) dut (
		.CLOCK(clock), .SYS_RST(sys_rst), .SOFT_RESET(soft_reset),
		.SPI_CS_N(cs_n), .SPI_SCLK(sclk), .SPI_MOSI(mosi),
		.SPI_MISO(miso), .SPI_MISO_EN(miso_en),
		.ADDRESS_CHAR_EVENT(ev[5]), .LINE_BREAK_EVENT(ev[4]),
		.STOP_CHAR_TWO_EVENT(ev[3]), .STOP_CHAR_ONE_EVENT(ev[2]),
		.RESUME_CHAR_TWO_EVENT(ev[1]), .RESUME_CHAR_ONE_EVENT(ev[0]),
		.MULTIDROP_MODE(multidrop), .SPECIAL_DETECT(special),
		.CLOCK_SETTLED(settled), .EXTERNAL_CLOCK(ext_clk),
		.CLOCK_DISABLED(clk_off), .GPI(gpi), .LINE_ACTIVITY(activity),
		.TX_QUEUED(tx_queued), .TX_BUSY(tx_busy), .TX_EMPTY(tx_empty),
		.TX_SERIAL(tx_serial), .RTS_LEVEL(rts_level),
		.HALF_DUPLEX_DELAYS(hd_delays), .IRQ_N(irq_n),
		.DIRECTION_OR_CLOCK_OUTPUT(dir_out),
		.DIRECTION_OUTPUT_EN(dir_en), .TX_PIN(tx_pin),
		.TX_PIN_EN(tx_en), .TX_GRANT(tx_grant), .RX_ACCEPT(rx_accept),
		.SLEEP_ACTIVE(sleep_active));

	always #12.5 clock = ~clock;

	// data-out enable must stand while the host clocks a frame
	always @(negedge clock) begin
		if (sclk && !miso_en) begin
			en_miss++;
		end
	end

	// ----------------------------------------------------------
	// helpers
	// ----------------------------------------------------------
	function automatic logic [7:0] bit_if(input logic on, input int b);
		return on ? (8'h01 << b) : 8'h00;
	endfunction

	task report_and_stop;
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task tick(input int n);
		repeat (n) @(negedge clock);
	endtask

	task rd(input logic [4:0] a, input logic [7:0] exp);
		logic [7:0] q;
		host.xfer(1'b0, a, 8'h00, q);
		chk(q, exp);
	endtask

	task wr(input logic [4:0] a, input logic [7:0] d);
		logic [7:0] q;
		host.xfer(1'b1, a, d, q);
	endtask

	task fire(input int i);
		ev[i] = 1'b1;
		@(negedge clock);
		ev = 6'h00;
		tick(4);
	endtask

	task wait_bit(input int b, input logic v, input int lim);
		int k;
		k = 0;
		n_checks++;
		while (outs[b] !== v && k < lim) begin
			@(negedge clock);
			k++;
		end
		if (outs[b] !== v) begin
			err_count++;
			$display("[ERR] %0t output %0d did not settle", $time, b);
			report_and_stop;
		end
	endtask

	// ----------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------
	initial begin
		clock = 1'b0; sys_rst = 1'b1; soft_reset = 1'b0; ev = 6'h00;
		multidrop = 1'b1; special = 1'b1; settled = 1'b0;
		ext_clk = 1'b0; clk_off = 1'b0; gpi = 4'h0; activity = 1'b0;
		tx_queued = 1'b0; tx_busy = 1'b0; tx_empty = 1'b0;
		tx_serial = 1'b0; rts_level = 1'b0; hd_delays = 8'h11;
		en = 8'h00; seed = 52882; err_count = 0; n_checks = 0;
		tick(12);
		sys_rst = 1'b0;
		chk({6'h00, miso_en, irq_n}, 8'h00);
		wait_bit(7, 1'b1, 200);
		for (int a = 5; a <= 9; a++) rd(5'(a), REG_RESET);
		wr(ADDR_SC_EN, 8'hFF);
		rd(ADDR_SC_EN, SC_MASK);
		wr(ADDR_ST_EN, 8'hFF);
		rd(ADDR_ST_EN, ST_MASK);
		rd(5'h1F, 8'h00);
		wr(ADDR_ST_EN, 8'h00);
		// special events, random enables
		for (int i = 0; i < 6; i++) begin
			en = 8'($random(seed));
			wr(ADDR_SC_EN, en);
			fire(i);
			rd(ADDR_SUMMARY, bit_if(en[i], SUM_SPECIAL_BIT));
			rd(ADDR_SC_FLAGS, bit_if(1'b1, i));
			rd(ADDR_SC_FLAGS, 8'h00);
			rd(ADDR_SUMMARY, 8'h00);
		end
		wr(ADDR_SC_EN, 8'h00);
		multidrop = 1'b0;
		special = 1'b0;
		for (int i = 3; i < 6; i++) fire(i);
		rd(ADDR_SC_FLAGS, 8'h10);
		// input changes, random enables
		for (int i = 0; i < 4; i++) begin
			en = 8'($random(seed));
			wr(ADDR_ST_EN, en & 8'h0F);
			gpi[i] = ~gpi[i];
			tick(6);
			rd(ADDR_ST_FLAGS, bit_if(1'b1, i));
			rd(ADDR_ST_FLAGS, 8'h00);
			rd(ADDR_SUMMARY, bit_if(en[i], SUM_STATUS_BIT));
		end
		// clock settled
		wr(ADDR_ST_EN, 8'h20);
		ext_clk = 1'b1;
		settled = 1'b1;
		tick(4);
		rd(ADDR_ST_FLAGS, 8'h00);
		ext_clk = 1'b0;
		tick(4);
		rd(ADDR_ST_FLAGS, 8'h20);
		rd(ADDR_ST_FLAGS, 8'h20);
		rd(ADDR_SUMMARY, 8'h04);
		rd(ADDR_SUMMARY, 8'h00);
		clk_off = 1'b1;
		tick(4);
		rd(ADDR_ST_FLAGS, 8'h00);
		settled = 1'b0;
		clk_off = 1'b0;
		// manual sleep
		wr(ADDR_ST_EN, 8'h40);
		wr(ADDR_FIRST_MODE_CONTROL, 8'h20);
		wait_bit(0, 1'b1, 10);
		rd(ADDR_FIRST_MODE_CONTROL, 8'h20);
		rd(ADDR_ST_FLAGS, 8'h40);
		rd(ADDR_ST_FLAGS, 8'h40);
		rd(ADDR_SUMMARY, 8'h04);
		wr(ADDR_FIRST_MODE_CONTROL, 8'h00);
		wait_bit(0, 1'b0, 10);
		rd(ADDR_ST_FLAGS, 8'h00);
		rd(ADDR_SUMMARY, 8'h04);
		// autosleep and idle restart
		wr(ADDR_ST_EN, 8'h00);
		wr(ADDR_FIRST_MODE_CONTROL, 8'h40);
		wait_bit(0, 1'b1, 40);
		activity = 1'b1;
		tick(1);
		activity = 1'b0;
		wait_bit(0, 1'b0, 10);
		tick(10);
		chk({7'h00, sleep_active}, 8'h00);
		wait_bit(0, 1'b1, 40);
		wr(ADDR_FIRST_MODE_CONTROL, 8'h00);
		wait_bit(0, 1'b0, 10);
		// automatic direction, one unit of setup and hold
		wr(ADDR_FIRST_MODE_CONTROL, 8'h10);
		tick(2);
		chk({6'h00, dir_out, tx_grant}, 8'h00);
		tx_queued = 1'b1;
		wait_bit(6, 1'b1, 4);
		tick(15);
		chk({7'h00, tx_grant}, 8'h00);
		wait_bit(2, 1'b1, 10);
		tx_busy = 1'b1;
		tx_queued = 1'b0;
		tick(5);
		tx_busy = 1'b0;
		tx_empty = 1'b1;
		tick(15);
		chk({7'h00, dir_out}, 8'h01);
		wait_bit(6, 1'b0, 10);
		rd(ADDR_SUMMARY, 8'h20);
		// interrupt pin as interrupt output
		wr(ADDR_FIRST_MODE_CONTROL, 8'h80);
		wr(ADDR_SC_EN, 8'h10);
		fire(4);
		wait_bit(7, 1'b0, 6);
		rd(ADDR_SC_FLAGS, 8'h10);
		rd(ADDR_SUMMARY, 8'h02);
		wait_bit(7, 1'b1, 6);
		// floats and disables
		wr(ADDR_FIRST_MODE_CONTROL, 8'h0F);
		tick(2);
		chk({3'h0, outs[5:1]}, 8'h08);
		tx_serial = 1'($random(seed));
		tx_busy = 1'b1;
		tick(2);
		chk({7'h00, tx_pin}, {7'h00, tx_serial});
		tx_busy = 1'b0;
		tick(2);
		chk({7'h00, tx_pin}, 8'h01);
		tx_serial = 1'b0;
		rts_level = 1'b1;
		wr(ADDR_FIRST_MODE_CONTROL, 8'h00);
		tick(2);
		chk({3'h0, outs[5:1]}, 8'h17);
		chk({7'h00, dir_out}, 8'h01);
		// software reset
		soft_reset = 1'b1;
		tick(4);
		soft_reset = 1'b0;
		tick(1);
		chk({7'h00, irq_n}, 8'h00);
		wait_bit(7, 1'b1, 200);
		rd(ADDR_SC_EN, REG_RESET);
		chk({7'h00, en_miss != 0}, 8'h00);
		report_and_stop;
	end
endmodule
